/* src/adc_port_pkg.sv */
/*
  Shared constants for the converter serial port: frame widths, status-pin
  role codes, reset values and conversion timing.
  Assumes a single 100 MHz system clock.
*/
package adc_port_pkg;

  localparam int          CLOCK_MHZ         = 100;
  localparam int          RESULT_BITS       = 12;
  localparam int          READ_CLOCKS       = 13;
  localparam int          WRITE_BITS        = 16;
  localparam int          CONVERT_MAX_NS    = 600;
  // longest time rounds down to whole cycles
  localparam int          CONVERT_CYCLES    = (CONVERT_MAX_NS * CLOCK_MHZ) / 1000;
  localparam int          SAR_DIVIDE        = 4;
  localparam int          SAR_STEPS         = RESULT_BITS + 1;

  // status pin role field, bits [5:4] of the written word
  localparam int          ROLE_LSB          = 4;
  localparam logic [1:0]  ROLE_ALERT        = 2'h0;
  localparam logic [1:0]  ROLE_BUSY         = 2'h1;
  localparam logic [1:0]  ROLE_GPO          = 2'h2;
  localparam int          GENERAL_OUTPUT_ZERO_BIT          = 0;
  localparam int          GENERAL_OUTPUT_ONE_BIT          = 1;
  localparam int          LIMIT_LSB         = 0;

  // command codes in the top nibble of a write word
  localparam logic [3:0]  CMD_CONFIG        = 4'h1;
  localparam logic [3:0]  CMD_LIMIT_LOW     = 4'h2;
  localparam logic [3:0]  CMD_LIMIT_HIGH    = 4'h3;

  localparam logic [11:0] CONFIG_RESET      = 12'h000;
  localparam logic [11:0] LIMIT_LOW_RESET   = 12'h000;
  localparam logic [11:0] LIMIT_HIGH_RESET  = 12'hFFF;

endpackage

/* src/adc_sar_engine.sv */
/*
  Successive-approximation sequencer driven by an internal step enable.
  Assumes a comparator decision input sampled on the same clock.
*/
`timescale 1ns/1ps
module adc_sar_engine
  import adc_port_pkg::*;
#(
  parameter int BITS = RESULT_BITS
)
(
  // clock and reset
  input  wire logic            clock,
  input  wire logic            rst,
  // control
  input  wire logic            step_en,
  input  wire logic            start,
  input  wire logic            compare_high,
  // result
  output logic                 busy,
  output logic                 done,
  output logic [BITS-1:0]      trial,
  output logic [BITS-1:0]      result
);

  logic [BITS-1:0] trial_q, trial_d, mask_q, mask_d, result_q, result_d;
  logic            busy_q, busy_d, done_q, done_d;

  // one trial bit resolved per step, msb first
  always_comb
  begin
    trial_d  = trial_q;
    mask_d   = mask_q;
    result_d = result_q;
    busy_d   = busy_q;
    done_d   = 1'b0;
    if (start)
    begin
      busy_d  = 1'b1;
      mask_d  = {1'b1, {(BITS-1){1'b0}}};
      trial_d = {1'b1, {(BITS-1){1'b0}}};
    end
    else if (busy_q && step_en)
    begin
      if (!compare_high)
        trial_d = trial_q & ~mask_q;
      mask_d = mask_q >> 1;
      trial_d = trial_d | (mask_q >> 1);
      if (mask_q[0])
      begin
        busy_d   = 1'b0;
        done_d   = 1'b1;
        result_d = compare_high ? trial_q : (trial_q & ~mask_q);
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      trial_q  <= '0;
      mask_q   <= '0;
      result_q <= '0;
      busy_q   <= 1'b0;
      done_q   <= 1'b0;
    end
    else
    begin
      trial_q  <= trial_d;
      mask_q   <= mask_d;
      result_q <= result_d;
      busy_q   <= busy_d;
      done_q   <= done_d;
    end
  end

  assign busy   = busy_q;
  assign done   = done_q;
  assign trial  = trial_q;
  assign result = result_q;

endmodule

/* src/adc_serial_conversion_port.sv */
/*
  Pin-level control of a 12-bit SAR converter: convert-start edge detect,
  internal conversion clock, framed serial port, status pin and outputs.
  Assumes start and serial input pins are asynchronous to clock, compare_high synchronous; sclk is slow enough to sample.
*/
// How it works
// - port acts only while chip select is held low by host
// - each result word sits inside one chip select low period
// - input bits captured on sclk falling edges, msb first
// - result bits shifted out on sclk falling edges
// - result sent msb first
// - convert start reacts to edges only, never levels
// - falling convert start edge holds sample and begins conversion
// - status pin role chosen by configuration field
// - alert role asserts when result leaves programmed limits
// - busy role asserts while conversion runs
// - gpo role drives software level; second gpo pin exists
// - result ready within 600 ns of start edge
// - sar steps from internal divider, independent of sclk
`timescale 1ns/1ps
module adc_serial_conversion_port
  import adc_port_pkg::*;
(
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst,
  // serial port pins
  input  wire logic                   chip_select_n,
  input  wire logic                   sclk,
  input  wire logic                   sdi,
  output logic                        sdo,
  output logic                        sdo_oe,
  // conversion
  input  wire logic                   conversion_start_n,
  input  wire logic                   compare_high,
  output logic                        track_hold,
  output logic [RESULT_BITS-1:0]      dac_trial,
  // status and general outputs
  output logic                        shared_status_pin,
  output logic                        general_output_one
);

  // two-stage synchronisers, first stage read only by the second
  logic [3:0] meta_q, sync_q, prev_q;
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      // idle levels: start high, select high, sclk low, sdi high; no false edge
      meta_q <= 4'hD;
      sync_q <= 4'hD;
      prev_q <= 4'hD;
    end
    else
    begin
      meta_q <= {conversion_start_n, chip_select_n, sclk, sdi};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  logic cs_low, sclk_fall, start_fall, sdi_s;
  // edges from synchronised copies; sclk is host-made, never driven here
  assign cs_low     = !sync_q[2];
  assign sclk_fall  = cs_low && prev_q[1] && !sync_q[1];
  assign start_fall = prev_q[3] && !sync_q[3];
  assign sdi_s      = sync_q[0];

  logic                   sar_busy, sar_done, start_ok;
  logic [RESULT_BITS-1:0] sar_result;
  // a start edge during a running conversion is dropped
  assign start_ok = start_fall && !sar_busy;

  // internal conversion clock enable, free of sclk; restarted by each
  // accepted start, since the comparator answers a clock after a new trial
  logic [1:0] div_q, div_d;
  logic       step_en;
  always_comb
  begin
    div_d   = (div_q == 2'(SAR_DIVIDE - 1)) ? 2'h0 : div_q + 2'h1;
    if (start_ok)
      div_d = 2'h0;
    step_en = (div_q == 2'(SAR_DIVIDE - 1));
  end
  always_ff @(posedge clock)
  begin
    if (rst)
      div_q <= 2'h0;
    else
      div_q <= div_d;
  end

  // 12 steps * 4 cycles + 3 sync cycles = 510 ns, inside the 600 ns budget
  adc_sar_engine #(
    .BITS         (RESULT_BITS)
  ) sar (
    .clock        (clock),
    .rst          (rst),
    .step_en      (step_en),
    .start        (start_ok),
    .compare_high (compare_high),
    .busy         (sar_busy),
    .done         (sar_done),
    .trial        (dac_trial),
    .result       (sar_result)
  );

  // serial shifter and config registers
  logic [WRITE_BITS-1:0]  in_q, in_d, out_q, out_d;
  logic [4:0]             cnt_q, cnt_d;
  logic [11:0]            cfg_q, cfg_d, lo_q, lo_d, hi_q, hi_d;
  logic                   sdo_q, sdo_d, oe_q, oe_d, alert_q, alert_d;
  logic [WRITE_BITS-1:0]  word;

  always_comb
  begin
    in_d    = in_q;
    out_d   = out_q;
    cnt_d   = cnt_q;
    cfg_d   = cfg_q;
    lo_d    = lo_q;
    hi_d    = hi_q;
    sdo_d   = sdo_q;
    oe_d    = cs_low;
    alert_d = alert_q;
    word    = {in_q[WRITE_BITS-2:0], sdi_s};
    if (!cs_low)
    begin
      // frame closed: reload result for next frame, msb on the pin
      cnt_d = 5'h0;
      out_d = {sar_result, 4'h0};
      sdo_d = sar_result[RESULT_BITS-1];
    end
    else if (sclk_fall)
    begin
      in_d  = word;
      cnt_d = cnt_q + 5'h1;
      out_d = {out_q[WRITE_BITS-2:0], 1'b0};
      sdo_d = out_q[WRITE_BITS-2];
      if (cnt_q == 5'(WRITE_BITS - 1))
      begin
        case (word[15:12])
          CMD_CONFIG:     cfg_d = word[11:0];
          CMD_LIMIT_LOW:  lo_d  = word[11:0];
          CMD_LIMIT_HIGH: hi_d  = word[11:0];
          default:        cfg_d = cfg_q;
        endcase
      end
    end
    // alert holds until the next in-limit result; new out-of-limit wins
    if (sar_done)
      alert_d = (sar_result < lo_q) || (sar_result > hi_q);
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      in_q    <= '0;
      out_q   <= '0;
      cnt_q   <= 5'h0;
      cfg_q   <= CONFIG_RESET;
      lo_q    <= LIMIT_LOW_RESET;
      hi_q    <= LIMIT_HIGH_RESET;
      sdo_q   <= 1'b0;
      oe_q    <= 1'b0;
      alert_q <= 1'b0;
    end
    else
    begin
      in_q    <= in_d;
      out_q   <= out_d;
      cnt_q   <= cnt_d;
      cfg_q   <= cfg_d;
      lo_q    <= lo_d;
      hi_q    <= hi_d;
      sdo_q   <= sdo_d;
      oe_q    <= oe_d;
      alert_q <= alert_d;
    end
  end

  // status pin role select, registered for a clean pin
  logic status_q, status_d, general_output_one_q;
  always_comb
  begin
    case (cfg_q[ROLE_LSB +: 2])
      ROLE_ALERT: status_d = alert_q;
      ROLE_BUSY:  status_d = sar_busy;
      ROLE_GPO:   status_d = cfg_q[GENERAL_OUTPUT_ZERO_BIT];
      default:    status_d = 1'b0;
    endcase
  end
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      status_q <= 1'b0;
      general_output_one_q   <= 1'b0;
    end
    else
    begin
      status_q <= status_d;
      general_output_one_q   <= cfg_q[GENERAL_OUTPUT_ONE_BIT];
    end
  end

  assign sdo                = sdo_q & oe_q;
  assign sdo_oe             = oe_q;
  assign track_hold         = sar_busy;
  assign shared_status_pin  = status_q;
  assign general_output_one = general_output_one_q;

endmodule

/* verification/adc_port_asserts.sv */
/* pin checker for the converter port.
   assumes a bind onto the port's top module */
`timescale 1ns/1ps
module adc_port_asserts
  import adc_port_pkg::*;
(
  // clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // pins
  input wire logic        chip_select_n,
  input wire logic        conversion_start_n,
  input wire logic        sdo,
  input wire logic        sdo_oe,
  input wire logic        track_hold,
  input wire logic [11:0] dac_trial,
  input wire logic        shared_status_pin,
  input wire logic        general_output_one
);
  logic [3:0] low_q;
  logic [3:0] low_d;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // start pin low time, saturating so it never wraps
  always_comb
  begin
    low_d = conversion_start_n ? 4'h0 : low_q + {3'h0, low_q != 4'hF};
  end
  always_ff @(posedge clock)
  begin
    low_q <= low_d;
  end
  sequence s_start;
    $fell(conversion_start_n) && !track_hold;
  endsequence
  a_oe_idle: assert property (chip_select_n [*5] |-> !sdo_oe) else $error("sdo on out of frame");
  a_sdo_quiet: assert property (!sdo_oe |-> !sdo) else $error("sdo high while off");
  a_oe_frame: assert property (!chip_select_n [*5] |-> sdo_oe) else $error("sdo off in frame");
  a_start_hold: assert property (s_start |-> ##[1:5] track_hold) else $error("no hold");
  a_trial_msb: assert property ($rose(track_hold) |-> ##[0:1] dac_trial == 12'h800) else $error("bad trial");
  a_conv_bound: assert property ($rose(track_hold) |-> ##[1:56] !track_hold) else $error("slow convert");
  a_level_start: assert property ($rose(track_hold) |-> low_q < 4'h8) else $error("level start");
  a_reset_clear: assert property (disable iff (1'b0) rst |=> !track_hold && !sdo_oe && !shared_status_pin
    && !general_output_one) else $error("reset left state");
endmodule
bind adc_serial_conversion_port adc_port_asserts chk_u (.clock, .rst, .chip_select_n, .conversion_start_n,
  .sdo, .sdo_oe, .track_hold, .dac_trial, .shared_status_pin, .general_output_one);

/* verification/spi_host_model.sv */
/* host serial controller: frames, clocks and shifts words.
   assumes a 100 MHz clock; sclk period is 80 ns */
`timescale 1ns/1ps
module spi_host_model
(
  // timing
  input  wire logic clock,
  // serial pins
  output logic      chip_select_n,
  output logic      sclk,
  output logic      sdi,
  input  wire logic sdo
);
  // sclk stands still between transfers
  initial
  begin
    chip_select_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b1;
  end
  // n clocks, msb first; act low means no frame at all
  task automatic xfer(input int n, input logic [15:0] w, input bit act, output logic [15:0] r);
    r = '0;
    @(posedge clock);
    chip_select_n <= !act;
    repeat (4) @(posedge clock);
    for (int i = n - 1; i >= 0; i--)
    begin
      sclk <= 1'b1;
      sdi <= w[i];
      repeat (4) @(posedge clock);
      r = {r[14:0], sdo};
      sclk <= 1'b0;
      repeat (4) @(posedge clock);
    end
    chip_select_n <= 1'b1;
    sdi <= !sdi; // released line shows no stale level
  endtask
endmodule

/* verification/test_adc_serial_conversion_port.sv */
/* self-checking bench for the converter port.
   assumes the host model owns the serial pins */
`timescale 1ns/1ps
module test_adc_serial_conversion_port import adc_port_pkg::*;;
  logic        clock, rst, chip_select_n, sclk, sdi, sdo, sdo_oe;
  logic        conversion_start_n, compare_high, track_hold, shared_status_pin, general_output_one, mid;
  logic [11:0] dac_trial, vin;
  int          bad_count, checks;
  adc_serial_conversion_port dut_u (.clock, .rst, .chip_select_n, .sclk, .sdi, .sdo, .sdo_oe, .conversion_start_n,
    .compare_high, .track_hold, .dac_trial, .shared_status_pin, .general_output_one);
  spi_host_model host_u (.clock, .chip_select_n, .sclk, .sdi, .sdo);
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // comparator: keep a trial bit while it does not exceed the input
  always @(posedge clock) compare_high <= (dac_trial <= vin);
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // start held low after the edge, so a level restart would show
  task automatic conv(input logic [11:0] v);
    int n;
    n = 0;
    vin = v;
    @(posedge clock);
    conversion_start_n <= 1'b0;
    while (track_hold !== 1'b1 && n < 20)
    begin
      @(negedge clock);
      n++;
    end
    chk("hold", 16'h0001, 16'(track_hold));
    if (n >= 20) summarize();
    while (track_hold === 1'b1 && n < 90)
    begin
      @(negedge clock);
      n++;
      if (n == 30) mid = shared_status_pin;
    end
    chk("time", 16'h0001, 16'(n <= 60));
    if (n >= 90) summarize();
    repeat (40) @(negedge clock);
    chk("restart", 16'h0000, 16'(track_hold));
    @(posedge clock);
    conversion_start_n <= 1'b1;
    repeat (8) @(negedge clock);
  endtask
  task automatic rd(input logic [11:0] v);
    logic [15:0] r;
    host_u.xfer(13, 16'h0000, 1'b1, r);
    chk("result", {3'h0, v, 1'b0}, r);
  endtask
  task automatic wr(input logic [3:0] c, input logic [11:0] d, input bit act);
    logic [15:0] r;
    host_u.xfer(16, {c, d}, act, r);
    repeat (8) @(negedge clock);
  endtask
  initial
  begin
    rst = 1'b1;
    conversion_start_n = 1'b1;
    vin = 12'h000;
    mid = 1'b0;
    bad_count = 0;
    checks = 0;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(negedge clock);
    chk("idle", 16'h0000, 16'({sdo_oe, track_hold, shared_status_pin, general_output_one}));
    conv(12'hA5C);
    rd(12'hA5C);
    wr(CMD_LIMIT_HIGH, 12'h100, 1'b1);
    conv(12'h100);
    chk("at limit", 16'h0000, 16'(shared_status_pin));
    conv(12'h200);
    chk("above", 16'h0001, 16'(shared_status_pin));
    wr(CMD_CONFIG, 12'h010, 1'b1);
    conv(12'h200);
    chk("busy", 16'h0002, 16'({mid, shared_status_pin}));
    wr(CMD_CONFIG, 12'h023, 1'b1);
    chk("gpo", 16'h0003, 16'({shared_status_pin, general_output_one}));
    wr(CMD_CONFIG, 12'h020, 1'b0);
    chk("no frame", 16'h0006, 16'({shared_status_pin, general_output_one, sdo_oe}));
    @(posedge clock);
    conversion_start_n <= 1'b0;
    repeat (10) @(posedge clock);
    rst <= 1'b1;
    conversion_start_n <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    chk("abort", 16'h0000, 16'({track_hold, shared_status_pin, general_output_one}));
    repeat (4) @(negedge clock);
    chk("cfg default", 16'h0000, 16'({shared_status_pin, general_output_one}));
    summarize();
  end
endmodule
